// *** design/prq_host.sv ***
// request controller: frames one request packet on the 64-bit request stream
// from software registers, and drains the completion stream
// assumes a wishbone classic master and a device that honours valid/ready
//
// Notes on behaviour
// RQ1: separate request and completion channels, each 64, 128 or 256 bits; here both channels are 64 bits.
// RQ2: request and completion channels run independently of each other.
// RQ3: posted requests are indivisible; non-posted ones complete later.
// RQ4: completions for non-posted requests arrive on the completion channel.
// RQ5: root complexes also send io and config; both send messages.
// RQ6: each request is one packet: 128-bit descriptor, then payload if any.
// RQ7: descriptor fills first two beats at 64 bits, one beat if wider.
// RQ8: dword-aligned payload starts right after the last descriptor dword.
// RQ9: head and tail dword byte enables are driven in both modes.
// RQ10: address-aligned payload starts next beat, first dword in any lane.
// RQ11: address-aligned mode reports first dword lane on a 3-bit offset.
// RQ12: hints go with memory requests only when the capability is enabled.
// RQ13: hint flag, 8-bit tag and 2-bit tag kind are given in beat one.
// RQ14: indirect tag sets indirect flag with hint flag; tag field holds index.
// RQ15: device looks up the indexed tag and inserts it into the packet.
// RQ16: descriptor layout depends on request type.
// RQ17: device copies 2-bit address type for memory and atomic requests.
// RQ18: address type: 00 untranslated, 01 translation request, 10 translated.
// RQ19: bits 63:2 hold dword address; upper 32 zero for short addresses.
// RQ20: dword count 74:64: writes 0-256, reads 1-1024, io exactly 1.
// RQ21: beats move on valid and ready; hold while stalled; last ends packet.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "prq_map.svh"
module prq_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // request out channel
  output logic [63:0] roc_tdata_o,
  output logic [1:0] roc_tkeep_o,
  output logic roc_tlast_o,
  output logic roc_tvalid_o,
  output logic [`PRQ_SB_W-1:0] request_sideband_bus_o,
  input wire logic roc_tready_i,
  // completion in channel
  input wire logic [63:0] cic_tdata_i,
  input wire logic cic_tvalid_i,
  input wire logic cic_tlast_i,
  output logic cic_tready_o
);
  // byte-lane merge for the ctrl, address, descriptor and sideband registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r;
  endfunction

  // legal dword count per request kind
  function automatic logic count_ok(input logic [1:0] kind, input logic [10:0] n);
    logic ok;
    ok = 1'b1;
    unique case (kind)
      prq_pkg::KIND_MWR: ok = (n <= `PRQ_MWR_MAX); // RQ20
      prq_pkg::KIND_MRD: ok = (n != 11'h000) && (n <= `PRQ_MRD_MAX); // RQ20
      prq_pkg::KIND_IO: ok = (n == 11'h001); // RQ20
      prq_pkg::KIND_OTHER: ok = 1'b1; // RQ5
    endcase
    return ok;
  endfunction

  logic [31:0] ctrl_r, ctrl_nxt, addr_lo_r, addr_lo_nxt, addr_hi_r, addr_hi_nxt;
  logic [31:0] desc2_r, desc2_nxt, desc3_r, desc3_nxt, side_r, side_nxt;
  logic [31:0] dat_r, dat_nxt, cpl_cnt, cpl_dw, wmerged, rd0, rd1;
  logic [15:0] req_cnt_r, req_cnt_nxt;
  logic [2:0] pidx_w_r, pidx_w_nxt;
  logic ack_r, ack_nxt, start_r, start_nxt, refused_r, refused_nxt;
  logic hit, busy, pld_we, refuse_set;
  prq_pkg::prq_state_t state_r, state_nxt;
  logic [10:0] pidx_r, pidx_nxt;
  logic [63:0] tdata_r, tdata_nxt;
  logic [1:0] tkeep_r, tkeep_nxt;
  logic tlast_r, tlast_nxt, tvalid_r, tvalid_nxt;
  logic [`PRQ_SB_W-1:0] sb_r, sb_nxt;
  logic [2:0] ridx1;
  logic [1:0] kind;
  logic [10:0] cnt;
  logic [11:0] sum;
  logic sl, v0, v1, with_pld, is_mem, hint;

  assign busy = (state_r != prq_pkg::ST_IDLE) || tvalid_r || start_r;

  // register slave: ack one cycle after the strobe, writes take effect then
  always_comb begin
    hit = wb_cyc_i && wb_stb_i && !ack_r;
    ack_nxt = hit;
    dat_nxt = 32'h0000_0000;
    ctrl_nxt = ctrl_r;
    addr_lo_nxt = addr_lo_r;
    addr_hi_nxt = addr_hi_r;
    desc2_nxt = desc2_r;
    desc3_nxt = desc3_r;
    side_nxt = side_r;
    pidx_w_nxt = pidx_w_r;
    req_cnt_nxt = req_cnt_r;
    start_nxt = 1'b0;
    refuse_set = 1'b0;
    pld_we = 1'b0;
    refused_nxt = refused_r;
    wmerged = 32'h0000_0000;
    if (hit && !wb_we_i) begin
      unique case (wb_adr_i)
        `PRQ_A_CTRL: dat_nxt = ctrl_r;
        `PRQ_A_ADDR_LO: dat_nxt = addr_lo_r;
        `PRQ_A_ADDR_HI: dat_nxt = addr_hi_r;
        `PRQ_A_DESC2: dat_nxt = desc2_r;
        `PRQ_A_DESC3: dat_nxt = desc3_r;
        `PRQ_A_SIDE: dat_nxt = side_r;
        `PRQ_A_STATUS: dat_nxt = {req_cnt_r, 14'h0000, refused_r, busy};
        `PRQ_A_CPL_CNT: dat_nxt = cpl_cnt;
        `PRQ_A_CPL_DW: dat_nxt = cpl_dw;
        `PRQ_A_PLD_IDX: dat_nxt = {29'h0000_0000, pidx_w_r};
        default: dat_nxt = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
    // request setup is frozen while a packet is in flight
    if (hit && wb_we_i) begin
      unique case (wb_adr_i)
        `PRQ_A_CTRL: if (!busy) begin
          wmerged = merge(ctrl_r, wb_dat_i, wb_sel_i);
          ctrl_nxt = wmerged;
          ctrl_nxt[`PRQ_C_START] = 1'b0;
          if (wmerged[`PRQ_C_START]) begin
            // refuse bad counts and reserved address type
            if (count_ok(wmerged[`PRQ_C_KIND], desc2_r[`PRQ_DCOUNT]) &&
                wmerged[`PRQ_C_ADDR_TYPE] != `PRQ_AT_RESERVED) begin // RQ18
              start_nxt = 1'b1;
              req_cnt_nxt = req_cnt_r + 16'h0001;
            end else begin
              refuse_set = 1'b1;
            end
          end
        end
        `PRQ_A_ADDR_LO: if (!busy) addr_lo_nxt = merge(addr_lo_r, wb_dat_i, wb_sel_i);
        `PRQ_A_ADDR_HI: if (!busy) addr_hi_nxt = merge(addr_hi_r, wb_dat_i, wb_sel_i);
        `PRQ_A_DESC2: if (!busy) desc2_nxt = merge(desc2_r, wb_dat_i, wb_sel_i);
        `PRQ_A_DESC3: if (!busy) desc3_nxt = merge(desc3_r, wb_dat_i, wb_sel_i);
        `PRQ_A_SIDE: if (!busy) side_nxt = merge(side_r, wb_dat_i, wb_sel_i);
        `PRQ_A_STATUS: if (wb_sel_i[0] && wb_dat_i[`PRQ_ST_REFUSED]) refused_nxt = 1'b0;
        `PRQ_A_PLD_IDX: if (wb_sel_i[0]) pidx_w_nxt = wb_dat_i[2:0];
        `PRQ_A_PLD_DATA: if (!busy) begin
          pld_we = 1'b1;
          pidx_w_nxt = pidx_w_r + 3'h1;
        end
        default: ;
      endcase
    end
    if (refuse_set) begin
      refused_nxt = 1'b1; // set wins over a clear in the same cycle
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      ctrl_r <= 32'h0000_0000;
      addr_lo_r <= 32'h0000_0000;
      addr_hi_r <= 32'h0000_0000;
      desc2_r <= 32'h0000_0000;
      desc3_r <= 32'h0000_0000;
      side_r <= 32'h0000_0000;
      pidx_w_r <= 3'h0;
      req_cnt_r <= 16'h0000;
      start_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      addr_lo_r <= addr_lo_nxt;
      addr_hi_r <= addr_hi_nxt;
      desc2_r <= desc2_nxt;
      desc3_r <= desc3_nxt;
      side_r <= side_nxt;
      pidx_w_r <= pidx_w_nxt;
      req_cnt_r <= req_cnt_nxt;
      start_r <= start_nxt;
      refused_r <= refused_nxt;
    end
  end

  // framer: one output stage, reloaded when empty or taken
  always_comb begin
    kind = ctrl_r[`PRQ_C_KIND];
    cnt = desc2_r[`PRQ_DCOUNT];
    with_pld = ctrl_r[`PRQ_C_WITH_PLD] && (cnt != 11'h000); // RQ6
    is_mem = (kind == prq_pkg::KIND_MWR) || (kind == prq_pkg::KIND_MRD);
    hint = ctrl_r[`PRQ_C_HINT] && ctrl_r[`PRQ_C_HINT_CAP] && is_mem; // RQ12
    // aligned mode: first dword in the lane its address picks
    sl = ctrl_r[`PRQ_C_ALIGNED] && (pidx_r == 11'h000) && addr_lo_r[2]; // RQ10
    v0 = !sl && (pidx_r < cnt);
    v1 = ({1'b0, pidx_r} + {11'h000, !sl}) < {1'b0, cnt};
    ridx1 = sl ? pidx_r[2:0] : pidx_r[2:0] + 3'h1;
    sum = {1'b0, pidx_r} + {11'h000, v0} + {11'h000, v1};
    state_nxt = state_r;
    pidx_nxt = pidx_r;
    tdata_nxt = tdata_r;
    tkeep_nxt = tkeep_r;
    tlast_nxt = tlast_r;
    sb_nxt = sb_r;
    tvalid_nxt = tvalid_r && !roc_tready_i; // RQ21
    if (!tvalid_r || roc_tready_i) begin // RQ21
      unique case (state_r)
        prq_pkg::ST_IDLE: if (start_r) begin
          // first beat: descriptor dwords 0 and 1, hint fields only here
          tdata_nxt = {ctrl_r[`PRQ_C_ADDR64] ? addr_hi_r : 32'h0000_0000, // RQ19
                       addr_lo_r[31:2], ctrl_r[`PRQ_C_ADDR_TYPE]}; // RQ7
          tkeep_nxt = 2'h3;
          tlast_nxt = 1'b0;
          tvalid_nxt = 1'b1;
          sb_nxt = '0;
          sb_nxt[`PRQ_SB_HEAD_BE] = side_r[`PRQ_S_HEAD_BE]; // RQ9
          sb_nxt[`PRQ_SB_TAIL_BE] = side_r[`PRQ_S_TAIL_BE]; // RQ9
          sb_nxt[`PRQ_SB_OFFSET] = ctrl_r[`PRQ_C_ALIGNED] ? {2'h0, addr_lo_r[2]} : 3'h0; // RQ11
          sb_nxt[`PRQ_SB_HINT] = hint; // RQ13
          sb_nxt[`PRQ_SB_INDIRECT] = hint && ctrl_r[`PRQ_C_INDIRECT]; // RQ14
          sb_nxt[`PRQ_SB_ST_KIND] = hint ? side_r[`PRQ_S_ST_KIND] : 2'h0; // RQ13
          sb_nxt[`PRQ_SB_ST_TAG] = hint ? side_r[`PRQ_S_ST_TAG] : 8'h00; // RQ13
          state_nxt = prq_pkg::ST_DESC1;
        end
        prq_pkg::ST_DESC1: begin
          tdata_nxt = {desc3_r, desc2_r}; // RQ7 RQ16
          tkeep_nxt = 2'h3;
          tlast_nxt = !with_pld; // RQ3
          tvalid_nxt = 1'b1;
          sb_nxt[`PRQ_SB_HINT] = 1'b0;
          sb_nxt[`PRQ_SB_INDIRECT] = 1'b0;
          sb_nxt[`PRQ_SB_ST_KIND] = 2'h0;
          sb_nxt[`PRQ_SB_ST_TAG] = 8'h00;
          pidx_nxt = 11'h000;
          state_nxt = with_pld ? prq_pkg::ST_DATA : prq_pkg::ST_IDLE;
        end
        prq_pkg::ST_DATA: begin
          // dword-aligned payload packs from lane 0
          tdata_nxt = {v1 ? rd1 : 32'h0000_0000, v0 ? rd0 : 32'h0000_0000}; // RQ8
          tkeep_nxt = {v1, v0};
          tvalid_nxt = 1'b1;
          pidx_nxt = sum[10:0];
          tlast_nxt = (sum >= {1'b0, cnt}); // RQ21
          if (sum >= {1'b0, cnt}) begin
            state_nxt = prq_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= prq_pkg::ST_IDLE;
      pidx_r <= 11'h000;
      tdata_r <= 64'h0000_0000_0000_0000;
      tkeep_r <= 2'h0;
      tlast_r <= 1'b0;
      tvalid_r <= 1'b0;
      sb_r <= '0;
    end else begin
      state_r <= state_nxt;
      pidx_r <= pidx_nxt;
      tdata_r <= tdata_nxt;
      tkeep_r <= tkeep_nxt;
      tlast_r <= tlast_nxt;
      tvalid_r <= tvalid_nxt;
      sb_r <= sb_nxt;
    end
  end

  // payload beyond eight dwords repeats the store modulo eight
  prq_pld_store u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(pld_we),
    .widx_i(pidx_w_r),
    .wdata_i(wb_dat_i),
    .ridx0_i(pidx_r[2:0]),
    .ridx1_i(ridx1),
    .rdata0_o(rd0),
    .rdata1_o(rd1)
  );

  // completions drain on their own
  prq_cpl_sink u_cpl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tdata_i(cic_tdata_i),
    .tvalid_i(cic_tvalid_i),
    .tlast_i(cic_tlast_i),
    .tready_o(cic_tready_o), // RQ2
    .pkt_cnt_o(cpl_cnt), // RQ4
    .first_dw_o(cpl_dw)
  );

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign roc_tdata_o = tdata_r;
  assign roc_tkeep_o = tkeep_r;
  assign roc_tlast_o = tlast_r;
  assign roc_tvalid_o = tvalid_r;
  assign request_sideband_bus_o = sb_r;
endmodule
`default_nettype wire

// *** design/prq_map.svh ***
// register map, fields, limits and sideband layout of the request controller
// assumes a 32-bit classic wishbone slave addressed by word index
`ifndef PRQ_MAP_SVH
`define PRQ_MAP_SVH
// word indices, byte address is four times the index
`define PRQ_A_CTRL 4'h0
`define PRQ_A_ADDR_LO 4'h1
`define PRQ_A_ADDR_HI 4'h2
`define PRQ_A_DESC2 4'h3
`define PRQ_A_DESC3 4'h4
`define PRQ_A_SIDE 4'h5
`define PRQ_A_STATUS 4'h6
`define PRQ_A_CPL_CNT 4'h7
`define PRQ_A_CPL_DW 4'h8
`define PRQ_A_PLD_IDX 4'h9
`define PRQ_A_PLD_DATA 4'hA
// control fields
`define PRQ_C_START 0
`define PRQ_C_ALIGNED 1
`define PRQ_C_ADDR64 2
`define PRQ_C_WITH_PLD 3
`define PRQ_C_KIND 5:4
`define PRQ_C_ADDR_TYPE 7:6
`define PRQ_C_HINT 8
`define PRQ_C_INDIRECT 9
`define PRQ_C_HINT_CAP 10
// sideband source fields
`define PRQ_S_HEAD_BE 3:0
`define PRQ_S_TAIL_BE 7:4
`define PRQ_S_ST_TAG 15:8
`define PRQ_S_ST_KIND 17:16
// status fields
`define PRQ_ST_BUSY 0
`define PRQ_ST_REFUSED 1
// descriptor and counts
`define PRQ_DCOUNT 10:0
`define PRQ_MWR_MAX 11'h100
`define PRQ_MRD_MAX 11'h400
`define PRQ_AT_RESERVED 2'h3
`define PRQ_PLD_DEPTH 8
// outgoing sideband bus layout
`define PRQ_SB_W 32
`define PRQ_SB_HEAD_BE 3:0
`define PRQ_SB_TAIL_BE 7:4
`define PRQ_SB_OFFSET 10:8
`define PRQ_SB_HINT 11
`define PRQ_SB_INDIRECT 12
`define PRQ_SB_ST_KIND 14:13
`define PRQ_SB_ST_TAG 22:15
`endif

// *** design/prq_pkg.sv ***
// types shared by the request controller files
// assumes nothing beyond a systemverilog compiler
package prq_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DESC1, ST_DATA} prq_state_t;
  typedef enum logic [1:0] {KIND_MWR, KIND_MRD, KIND_IO, KIND_OTHER} prq_kind_t;
endpackage

// *** design/prq_pld_store.sv ***
// payload dword store: flip-flops, one write port, two read ports
// assumes writes come from the register slave, reads from the framer
`timescale 1ns/1ps
`default_nettype none
`include "prq_map.svh"
module prq_pld_store (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write port
  input wire logic we_i,
  input wire logic [2:0] widx_i,
  input wire logic [31:0] wdata_i,
  // read ports
  input wire logic [2:0] ridx0_i,
  input wire logic [2:0] ridx1_i,
  output logic [31:0] rdata0_o,
  output logic [31:0] rdata1_o
);
  logic [31:0] mem_r [`PRQ_PLD_DEPTH];
  logic [31:0] mem_nxt [`PRQ_PLD_DEPTH];

  // one entry per step, written only when addressed
  for (genvar g = 0; g < `PRQ_PLD_DEPTH; g++) begin : g_ent
    always_comb begin
      mem_nxt[g] = mem_r[g];
      if (we_i && widx_i == 3'(g)) begin
        mem_nxt[g] = wdata_i;
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mem_r[g] <= 32'h0000_0000;
      end else begin
        mem_r[g] <= mem_nxt[g];
      end
    end
  end

  // combinational read; the framer registers the beat
  assign rdata0_o = mem_r[ridx0_i];
  assign rdata1_o = mem_r[ridx1_i];
endmodule
`default_nettype wire

// *** design/prq_cpl_sink.sv ***
// completion channel consumer: ready from the second cycle after reset, counts packets, keeps first dword
// assumes a 64-bit stream source that holds data while ready is low
`timescale 1ns/1ps
`default_nettype none
module prq_cpl_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // completion stream
  input wire logic [63:0] tdata_i,
  input wire logic tvalid_i,
  input wire logic tlast_i,
  output logic tready_o,
  // status
  output logic [31:0] pkt_cnt_o,
  output logic [31:0] first_dw_o
);
  logic ready_r, ready_nxt, sop_r, sop_nxt;
  logic [31:0] cnt_r, cnt_nxt, dw_r, dw_nxt;
  logic take;

  // apart from the request side, so completions never stall requests
  always_comb begin
    take = ready_r && tvalid_i;
    ready_nxt = 1'b1;
    sop_nxt = sop_r;
    cnt_nxt = cnt_r;
    dw_nxt = dw_r;
    if (take) begin
      if (sop_r) begin
        dw_nxt = tdata_i[31:0];
      end
      sop_nxt = tlast_i;
      if (tlast_i) begin
        cnt_nxt = cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_r <= 1'b0;
      sop_r <= 1'b1;
      cnt_r <= 32'h0000_0000;
      dw_r <= 32'h0000_0000;
    end else begin
      ready_r <= ready_nxt;
      sop_r <= sop_nxt;
      cnt_r <= cnt_nxt;
      dw_r <= dw_nxt;
    end
  end

  assign tready_o = ready_r;
  assign pkt_cnt_o = cnt_r;
  assign first_dw_o = dw_r;
endmodule
`default_nettype wire

// *** design/prq_pkg_placeholder_unused.sv ***
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** verif/prq_host_monitor.sv ***
// checker for the request controller, top module ports only
// assumes one clock and the synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
`include "prq_map.svh"
module prq_host_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // request and completion streams
  input wire logic [63:0] roc_tdata_o,
  input wire logic [1:0] roc_tkeep_o,
  input wire logic roc_tlast_o,
  input wire logic roc_tvalid_o,
  input wire logic [`PRQ_SB_W-1:0] request_sideband_bus_o,
  input wire logic roc_tready_i,
  input wire logic cic_tvalid_i,
  input wire logic cic_tready_o
);
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take, in_pkt_r, in_pkt_nxt;
  assign take = roc_tvalid_o && roc_tready_i;
  // marks beats after the first of a packet
  always_comb begin
    in_pkt_nxt = in_pkt_r;
    if (take) begin
      in_pkt_nxt = !roc_tlast_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_pkt_r <= 1'b0;
    end else begin
      in_pkt_r <= in_pkt_nxt;
    end
  end
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  ack_on_request_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  read_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("data outside ack");
  stall_hold_a: assert property (roc_tvalid_o && !roc_tready_i |=> roc_tvalid_o &&
    $stable(roc_tdata_o) && $stable(roc_tkeep_o) && $stable(roc_tlast_o) &&
    $stable(request_sideband_bus_o)) else $error("stall change");
  desc_not_last_a: assert property (roc_tvalid_o && !in_pkt_r |-> !roc_tlast_o)
    else $error("last in descriptor");
  hint_first_only_a: assert property (take && !roc_tlast_o |=>
    !(roc_tvalid_o && request_sideband_bus_o[`PRQ_SB_HINT])) else $error("late hint");
  at_not_reserved_a: assert property (roc_tvalid_o && !in_pkt_r |->
    roc_tdata_o[1:0] != `PRQ_AT_RESERVED) else $error("reserved type");
  cpl_ready_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> cic_tready_o)
    else $error("no cpl ready");
  cover property (roc_tvalid_o && !roc_tready_i);
  cover property (take && request_sideband_bus_o[`PRQ_SB_HINT]);
  cover property (take && roc_tkeep_o == 2'h2);
  cover property (cic_tvalid_i && cic_tready_o);
endmodule
bind prq_host prq_host_monitor prq_host_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .roc_tdata_o(roc_tdata_o), .roc_tkeep_o(roc_tkeep_o), .roc_tlast_o(roc_tlast_o),
  .roc_tvalid_o(roc_tvalid_o), .request_sideband_bus_o(request_sideband_bus_o),
  .roc_tready_i(roc_tready_i), .cic_tvalid_i(cic_tvalid_i), .cic_tready_o(cic_tready_o));
`default_nettype wire

// *** verif/prq_dev_model.sv ***
// device model: takes request beats, sends completions
// assumes the bench reads the beat queues and calls send_cpl by hierarchy
`timescale 1ns/1ps
`default_nettype none
module prq_dev_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stall select
  input wire logic stall_i,
  // request out channel, 64-bit width
  input wire logic [63:0] tdata_i,
  input wire logic [1:0] tkeep_i,
  input wire logic tlast_i,
  input wire logic tvalid_i,
  input wire logic [31:0] sb_i,
  output logic tready_o,
  // completion in channel
  output logic [63:0] cdata_o,
  output logic cvalid_o,
  output logic clast_o,
  input wire logic cready_i
);
  logic [63:0] beat_q[$];
  logic [1:0] keep_q[$];
  logic last_q[$];
  logic [31:0] sb_q[$];
  initial begin
    tready_o = 1'b0;
    cdata_o = 64'h0000_0000_0000_0000;
    cvalid_o = 1'b0;
    clast_o = 1'b0;
  end
  // ready toggles every cycle while stall is set, else stays high; beats move on valid and ready
  always @(posedge clk_i) begin
    if (rst_i) begin
      tready_o <= 1'b0;
    end else begin
      tready_o <= stall_i ? ~tready_o : 1'b1;
    end
    if (!rst_i && tvalid_i && tready_o) begin
      beat_q.push_back(tdata_i);
      keep_q.push_back(tkeep_i);
      last_q.push_back(tlast_i);
      sb_q.push_back(sb_i);
    end
  end
  // two-beat completion, independent of the request side
  task automatic send_cpl(input logic [31:0] dw);
    int k;
    @(posedge clk_i);
    cvalid_o <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      cdata_o <= (b == 0) ? {~dw, dw} : {dw, ~dw};
      clast_o <= (b == 1);
      k = 0;
      do begin @(posedge clk_i); k++; end while (cready_i !== 1'b1 && k < 100);
    end
    cvalid_o <= 1'b0;
    clast_o <= 1'b0;
    cdata_o <= {~dw, dw}; // data goes back to the first beat once released
  endtask
endmodule
`default_nettype wire

// *** verif/tb_prq_host.sv ***
// self-checking bench for the request controller
// assumes the device model on the streams and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "prq_map.svh"
module tb_prq_host;
  logic clk_i, rst_i, cyc, stb, we, stall, tlast, tvalid, tready, cvalid, clast, cready, ack;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, sb, q;
  logic [63:0] tdata, cdata;
  logic [1:0] keep;
  int error_cnt, n_compared, base;
  // ctrl, addr lo, addr hi, count, sideband
  logic [31:0] rows [7][5] = '{
    '{32'h0000_0011, 32'h1000_0004, 32'hFFFF_0000, 32'h0000_0001, 32'h0000_00F3},
    '{32'h0000_0055, 32'h1000_0008, 32'h0000_0007, 32'h0000_0400, 32'h0000_0081},
    '{32'h0000_0585, 32'h1000_000C, 32'h0000_0009, 32'h0000_0000, 32'h0002_A5FF},
    '{32'h0000_0711, 32'h1000_0010, 32'h0000_0000, 32'h0000_0001, 32'h0001_071F},
    '{32'h0000_0111, 32'h1000_0014, 32'h0000_0000, 32'h0000_0001, 32'h0003_33FF},
    '{32'h0000_0521, 32'h1000_0018, 32'h0000_0000, 32'h0000_0001, 32'h0001_440F},
    '{32'h0000_0031, 32'h1000_001C, 32'h0000_0000, 32'h0000_0001, 32'h0000_0011}};
  // refused: bad count per kind, reserved address type
  logic [31:0] bad [4][2] = '{'{32'h0000_0001, 32'h0000_0101}, '{32'h0000_0011, 32'h0000_0000},
    '{32'h0000_0021, 32'h0000_0002}, '{32'h0000_00D1, 32'h0000_0001}};
  prq_host prq_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .roc_tdata_o(tdata), .roc_tkeep_o(keep), .roc_tlast_o(tlast),
    .roc_tvalid_o(tvalid), .request_sideband_bus_o(sb), .roc_tready_i(tready),
    .cic_tdata_i(cdata), .cic_tvalid_i(cvalid), .cic_tlast_i(clast), .cic_tready_o(cready));
  prq_dev_model prq_dev_model_i (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .tdata_i(tdata),
    .tkeep_i(keep), .tlast_i(tlast), .tvalid_i(tvalid), .sb_i(sb), .tready_o(tready),
    .cdata_o(cdata), .cvalid_o(cvalid), .clast_o(clast), .cready_i(cready));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // classic cycle, held until ack is sampled
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; wdat <= d; sel <= 4'hF;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (ack !== 1'b1) begin error_cnt++; stop_test(); end
  endtask
  task automatic wait_beats(input int n);
    int k;
    k = 0;
    while (prq_dev_model_i.beat_q.size() < n && k < 300) begin @(posedge clk_i); k++; end
    if (k >= 300) begin error_cnt++; stop_test(); end
  endtask
  task automatic send(input logic [31:0] c, input logic [31:0] lo, input logic [31:0] hi,
                      input logic [31:0] d2, input logic [31:0] sd);
    wb(`PRQ_A_ADDR_LO, 1'b1, lo); wb(`PRQ_A_ADDR_HI, 1'b1, hi); wb(`PRQ_A_DESC2, 1'b1, d2);
    wb(`PRQ_A_DESC3, 1'b1, 32'h5A5A_0000 ^ d2); wb(`PRQ_A_SIDE, 1'b1, sd); wb(`PRQ_A_CTRL, 1'b1, c);
  endtask
  // descriptor beats and first sideband, from the fields written
  task automatic chk_desc(input logic [31:0] c, input logic [31:0] lo, input logic [31:0] hi,
                          input logic [31:0] d2, input logic [31:0] sd, input logic [2:0] off);
    logic ok;
    ok = c[8] && c[10] && c[5:4] < 2'h2;
    chk(prq_dev_model_i.beat_q[base], {c[2] ? hi : 32'h0, lo[31:2], c[7:6]});
    chk(prq_dev_model_i.beat_q[base + 1], {32'h5A5A_0000 ^ d2, d2});
    chk(prq_dev_model_i.last_q[base + 1], !(c[3] && d2[10:0] != 0));
    chk(prq_dev_model_i.sb_q[base][12:0], {ok & c[9], ok, off, sd[7:0]});
    if (ok) chk(prq_dev_model_i.sb_q[base][22:13], {sd[15:8], sd[17:16]});
  endtask
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0;
    wdat = 32'h0000_0000; stall = 1'b0; error_cnt = 0; n_compared = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // ordinary requests by row
    for (int i = 0; i < 7; i++) begin
      base = prq_dev_model_i.beat_q.size();
      send(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4]);
      wait_beats(base + 2);
      chk_desc(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4], 3'h0);
    end
    // payload in both alignments under stalls, completions meanwhile
    stall <= 1'b1;
    for (int al = 0; al < 2; al++) begin
      wb(`PRQ_A_PLD_IDX, 1'b1, 32'h0000_0000);
      for (int i = 0; i < 3; i++) wb(`PRQ_A_PLD_DATA, 1'b1, 32'hD000_0000 + i);
      base = prq_dev_model_i.beat_q.size();
      fork
        send(al ? 32'h0000_000B : 32'h0000_0009, 32'h2000_0000 + 4 * al, 0, 3, 32'h0000_00FF);
        if (al == 0) begin
          prq_dev_model_i.send_cpl(32'hC001_0001);
          prq_dev_model_i.send_cpl(32'hC002_0002);
        end
      join
      wait_beats(base + 4);
      chk_desc(al ? 32'h0000_000B : 32'h0000_0009, 32'h2000_0000 + 4 * al, 0, 3, 32'h0000_00FF,
               al[2:0]);
      if (al == 0) begin
        chk(prq_dev_model_i.beat_q[base + 2], 64'hD000_0001_D000_0000);
        chk(prq_dev_model_i.keep_q[base + 3], 2'h1);
        chk(prq_dev_model_i.beat_q[base + 3][31:0], 32'hD000_0002);
      end else begin
        chk(prq_dev_model_i.beat_q[base + 2][63:32], 32'hD000_0000);
        chk(prq_dev_model_i.keep_q[base + 2], 2'h2);
        chk(prq_dev_model_i.beat_q[base + 3], 64'hD000_0002_D000_0001);
      end
      chk(prq_dev_model_i.last_q[base + 3], 1'b1);
    end
    wb(`PRQ_A_CPL_CNT, 1'b0, 32'h0000_0000);
    chk(q, 64'h2);
    wb(`PRQ_A_CPL_DW, 1'b0, 32'h0000_0000);
    chk(q, 64'hC002_0002);
    // refused starts send nothing and set the sticky flag
    stall <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      base = prq_dev_model_i.beat_q.size();
      send(bad[i][0], 32'h3000_0000, 0, bad[i][1], 0);
      wb(`PRQ_A_STATUS, 1'b0, 32'h0000_0000);
      chk(q[`PRQ_ST_REFUSED], 1'b1);
      chk(prq_dev_model_i.beat_q.size(), base);
      wb(`PRQ_A_STATUS, 1'b1, 32'h0000_0002);
      wb(`PRQ_A_STATUS, 1'b0, 32'h0000_0000);
      chk(q[`PRQ_ST_REFUSED], 1'b0);
    end
    // unmapped reads zero
    wb(4'hF, 1'b1, 32'hFFFF_FFFF);
    wb(4'hF, 1'b0, 32'h0000_0000);
    chk(q, 64'h0);
    // reset inside a stalled packet
    stall <= 1'b1;
    send(rows[0][0], rows[0][1], rows[0][2], rows[0][3], rows[0][4]);
    wait_beats(prq_dev_model_i.beat_q.size() + 1);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(tvalid, 1'b0);
    wb(`PRQ_A_STATUS, 1'b0, 32'h0000_0000);
    chk(q, 64'h0);
    wb(`PRQ_A_CPL_CNT, 1'b0, 32'h0000_0000);
    chk(q, 64'h0);
    stop_test();
  end
endmodule
`default_nettype wire
